// [rtl/ddr_link_pkg.sv]
// Package for the double data rate chip-to-chip channel.
// Assumes a single user clock at twice the forwarded link clock rate.
package ddr_link_pkg;
  localparam int LINK_W_DEF = 8;
  localparam int RATIO_DEF = 2;
  localparam int TX_DEPTH_DEF = 64;
  localparam int RX_DEPTH_DEF = 128;
  localparam int PF_DEPTH = 4;
  localparam int PF_AW = 2;
  localparam int NEARLY_FULL_FREE = 32;
  localparam logic BP_RESET = 1'h1;

  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_LINK_UP = 3'h2,
    ST_RUN = 3'h4
  } rst_state_t;

  // Lock reports of the four clock generators.
  typedef struct packed {
    logic rx_core;
    logic rx_deskew;
    logic tx_core;
    logic link_gen;
  } lock_t;

  function automatic int ser_slice_w(input int w);
    ser_slice_w = (w % 4 == 0) ? 4 : ((w % 2 == 0) ? 2 : 1);
  endfunction : ser_slice_w

  function automatic int pf_slice_w(input int w);
    pf_slice_w = (w % 8 == 0) ? 8 : ((w % 4 == 0) ? 4 : 2);
  endfunction : pf_slice_w
endpackage : ddr_link_pkg

// [rtl/ddr_fifo_chip_link.sv]
// Transmit and receive ends of a double data rate chip-to-chip channel.
// Assumes clk is the doubled transmit clock and link_rx_clk the doubled recovered receive clock.
// Summary of operation
// - Flag high in the high half means data in that half and the next low half.
// - Flag low in the high half means no data; receiver ignores the bus then.
// - Transmit buffer is a RAM FIFO with a write port wider than the read side.
// - Serializer slices send the lower half first, then the upper half.
// - Bus is covered by equal slices of width 4, 2 or 1, largest that divides.
// - Send a word whenever the FIFO is not empty and backpressure is low.
// - Valid flag passes through its own one-bit serializer path, aligned with data.
// - Deserializer captures lower then upper half and loads a double-width register.
// - Valid flag is made single rate; its first captured bit is stored with the pair, its second-half bit steers the half phase.
// - A four-word FIFO re-times data from the receive clock into the user clock.
// - Reading the phase FIFO starts later than writing after reset.
// - Once started, the phase FIFO is written every second receive clock cycle and read whenever it is not empty.
// - Phase FIFO storage is slices of width 8, 4 or 2, plus a flag slice.
// - Receive RAM FIFO is written, widened, only when the read flag is true.
// - Backpressure is high when the receive FIFO has 32 or fewer free words.
// - User reset holds from board reset until all four clock generators lock.
// - Full flag low means the user may write on the next clock edge.
// - Write requests made while full are ignored.
// - Valid flag is low during every low half of the link clock.
// - Far-end reset holds until the link clock generator is locked.
// - Link clock runs at half the bit rate, one bit per line each half.
`timescale 1ns/1ns
module ddr_fifo_chip_link #(
  parameter int LINK_W = ddr_link_pkg::LINK_W_DEF,
  parameter int RATIO = ddr_link_pkg::RATIO_DEF,
  parameter int TX_DEPTH = ddr_link_pkg::TX_DEPTH_DEF,
  parameter int RX_DEPTH = ddr_link_pkg::RX_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic rst_b,
  input wire ddr_link_pkg::lock_t lock_in,
  output logic tx_user_reset,
  output logic far_end_reset,
  input wire logic tx_write_request,
  input wire logic [2*LINK_W*RATIO-1:0] tx_write_word,
  output logic tx_fifo_full_flag,
  output logic forwarded_link_clock,
  output logic parcel_valid_flag,
  output logic [LINK_W-1:0] ddr_link_bus,
  input wire logic receiver_backpressure_in,
  input wire logic link_rx_clk,
  input wire logic rx_parcel_valid_flag,
  input wire logic [LINK_W-1:0] rx_ddr_link_bus,
  output logic receiver_backpressure,
  input wire logic rx_read_request,
  output logic [2*LINK_W*RATIO-1:0] rx_read_word,
  output logic rx_empty_flag
);
  localparam int PAIR_W = 2 * LINK_W;
  localparam int WORD_W = PAIR_W * RATIO;
  localparam int TX_AW = $clog2(TX_DEPTH);
  localparam int RX_AW = $clog2(RX_DEPTH);
  localparam int KW = (RATIO > 1) ? $clog2(RATIO) : 1;
  localparam int SER_W = ddr_link_pkg::ser_slice_w(LINK_W);
  localparam int PF_W = ddr_link_pkg::pf_slice_w(PAIR_W);
  localparam int PA = ddr_link_pkg::PF_AW;

  // Reset sequencing on lock reports.
  ddr_link_pkg::lock_t lock_s1, lock_s;
  ddr_link_pkg::rst_state_t st, next_st;
  logic next_tx_user_reset, next_far_end_reset, run;

  always_comb begin
    next_st = st;
    case (st)
      ddr_link_pkg::ST_RESET: if (lock_s.link_gen) next_st = ddr_link_pkg::ST_LINK_UP;
      ddr_link_pkg::ST_LINK_UP: begin
        if (!lock_s.link_gen) next_st = ddr_link_pkg::ST_RESET;
        else if (&lock_s) next_st = ddr_link_pkg::ST_RUN;
      end
      ddr_link_pkg::ST_RUN: if (!(&lock_s)) next_st = ddr_link_pkg::ST_RESET;
      default: next_st = ddr_link_pkg::ST_RESET;
    endcase
    next_tx_user_reset = (next_st != ddr_link_pkg::ST_RUN);
    next_far_end_reset = (next_st == ddr_link_pkg::ST_RESET);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_s1 <= '0;
      lock_s <= '0;
      st <= ddr_link_pkg::ST_RESET;
      tx_user_reset <= 1'h1;
      far_end_reset <= 1'h1;
    end else if (ce) begin
      lock_s1 <= lock_in;
      lock_s <= lock_s1;
      st <= next_st;
      tx_user_reset <= next_tx_user_reset;
      far_end_reset <= next_far_end_reset;
    end
  end
  assign run = (st == ddr_link_pkg::ST_RUN);

  // Transmit FIFO, narrowing and serializer on the doubled clock.
  logic [WORD_W-1:0] tx_mem [TX_DEPTH];
  logic [TX_AW:0] tx_wp, tx_rp, next_tx_wp, next_tx_rp, tx_cnt;
  logic [WORD_W-1:0] hold, next_hold, src;
  logic [PAIR_W-1:0] pair;
  logic [LINK_W-1:0] ser_lo, ser_hi, hi, next_hi, next_bus;
  logic [KW-1:0] k, next_k;
  logic ph, next_ph, busy, next_busy, bp_s1, bp_s, tx_push, tx_pop, tx_empty, send;
  logic next_full, next_lclk, next_flag;

  always_comb begin
    tx_cnt = tx_wp - tx_rp;
    tx_empty = (tx_wp == tx_rp);
    tx_push = run && tx_write_request && !tx_fifo_full_flag;
    next_ph = run ? ~ph : 1'h1;
    tx_pop = run && !next_ph && !busy && !tx_empty && !bp_s;
    send = !next_ph && (busy || tx_pop);
    src = busy ? hold : tx_mem[tx_rp[TX_AW-1:0]];
    pair = src[k*PAIR_W +: PAIR_W];
    for (int s = 0; s < LINK_W / SER_W; s++) begin
      ser_lo[s*SER_W +: SER_W] = pair[2*s*SER_W +: SER_W];
      ser_hi[s*SER_W +: SER_W] = pair[2*s*SER_W+SER_W +: SER_W];
    end
    next_hold = hold;
    next_busy = busy;
    next_k = k;
    next_hi = hi;
    if (!next_ph) begin
      next_flag = send;
      next_bus = send ? ser_lo : '0;
      next_hi = ser_hi;
      if (tx_pop) next_hold = src;
      if (send) begin
        next_busy = (k != KW'(RATIO - 1));
        next_k = (k == KW'(RATIO - 1)) ? '0 : KW'(k + 1'h1);
      end
    end else begin
      next_flag = 1'h0;
      next_bus = hi;
    end
    next_lclk = !next_ph;
    next_tx_wp = tx_wp + {{TX_AW{1'h0}}, tx_push};
    next_tx_rp = tx_rp + {{TX_AW{1'h0}}, tx_pop};
    next_full = ((next_tx_wp - next_tx_rp) == (TX_AW + 1)'(TX_DEPTH));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_wp <= '0;
      tx_rp <= '0;
      hold <= '0;
      hi <= '0;
      k <= '0;
      ph <= 1'h1;
      busy <= 1'h0;
      bp_s1 <= ddr_link_pkg::BP_RESET;
      bp_s <= ddr_link_pkg::BP_RESET;
      tx_fifo_full_flag <= 1'h0;
      forwarded_link_clock <= 1'h0;
      parcel_valid_flag <= 1'h0;
      ddr_link_bus <= '0;
    end else if (ce) begin
      tx_wp <= next_tx_wp;
      tx_rp <= next_tx_rp;
      hold <= next_hold;
      hi <= next_hi;
      k <= next_k;
      ph <= next_ph;
      busy <= next_busy;
      bp_s1 <= receiver_backpressure_in;
      bp_s <= bp_s1;
      tx_fifo_full_flag <= next_full;
      forwarded_link_clock <= next_lclk;
      parcel_valid_flag <= next_flag;
      ddr_link_bus <= next_bus;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && tx_push) tx_mem[tx_wp[TX_AW-1:0]] <= tx_write_word;
  end

  // Receive capture and phase FIFO write side, on the recovered doubled clock.
  logic lce_s1, lce, hf, next_hf, flag_lo, pf_full, pf_we;
  logic [LINK_W-1:0] lo;
  logic [PA:0] wp_bin, wp_gray, next_wp_bin, rg_s1, rg_s2;
  logic [PA:0] rp_bin, rp_gray, next_rp_bin, wg_s1, wg_s2;
  logic [PAIR_W-1:0] pf_in, pf_out;
  logic pf_flag_out;

  always_comb begin
    for (int s = 0; s < LINK_W / SER_W; s++) begin
      pf_in[2*s*SER_W +: SER_W] = lo[s*SER_W +: SER_W];
      pf_in[2*s*SER_W+SER_W +: SER_W] = rx_ddr_link_bus[s*SER_W +: SER_W];
    end
    pf_full = (wp_gray == {~rg_s2[PA:PA-1], rg_s2[PA-2:0]});
    pf_we = lce && hf && !pf_full;
    next_hf = rx_parcel_valid_flag | ~hf;
    next_wp_bin = wp_bin + {{PA{1'h0}}, pf_we};
  end

  always_ff @(posedge link_rx_clk or negedge rst_b) begin
    if (!rst_b) begin
      lce_s1 <= 1'h0;
      lce <= 1'h0;
      hf <= 1'h0;
      flag_lo <= 1'h0;
      lo <= '0;
      wp_bin <= '0;
      wp_gray <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      lce_s1 <= ce;
      lce <= lce_s1;
      if (lce) begin
        hf <= next_hf;
        flag_lo <= rx_parcel_valid_flag;
        lo <= rx_ddr_link_bus;
        wp_bin <= next_wp_bin;
        wp_gray <= next_wp_bin ^ (next_wp_bin >> 1);
        rg_s1 <= rp_gray;
        rg_s2 <= rg_s1;
      end
    end
  end

  // Phase FIFO read side and receive RAM FIFO on the user clock.
  logic pf_pop;

  for (genvar s = 0; s < PAIR_W / PF_W; s++) begin : g_pf
    logic [PF_W-1:0] m [ddr_link_pkg::PF_DEPTH];
    always_ff @(posedge link_rx_clk) begin
      if (pf_we) m[wp_bin[PA-1:0]] <= pf_in[s*PF_W +: PF_W];
    end
    assign pf_out[s*PF_W +: PF_W] = m[rp_bin[PA-1:0]];
  end
  logic fm [ddr_link_pkg::PF_DEPTH];
  always_ff @(posedge link_rx_clk) begin
    if (pf_we) fm[wp_bin[PA-1:0]] <= flag_lo;
  end
  assign pf_flag_out = fm[rp_bin[PA-1:0]];

  logic [WORD_W-1:0] rx_mem [RX_DEPTH];
  logic [WORD_W-1:0] acc, next_acc, next_rd;
  logic [RX_AW:0] rx_wp, rx_rp, next_rx_wp, next_rx_rp, rx_cnt, next_cnt;
  logic [KW-1:0] ak, next_ak;
  logic rx_push, rx_pop, next_bp, next_empty;

  always_comb begin
    pf_pop = (rp_gray != wg_s2);
    next_rp_bin = rp_bin + {{PA{1'h0}}, pf_pop};
    rx_cnt = rx_wp - rx_rp;
    next_acc = acc;
    next_ak = ak;
    rx_push = 1'h0;
    if (pf_pop && pf_flag_out) begin
      next_acc[ak*PAIR_W +: PAIR_W] = pf_out;
      next_ak = (ak == KW'(RATIO - 1)) ? '0 : KW'(ak + 1'h1);
      rx_push = (ak == KW'(RATIO - 1)) && (rx_cnt != (RX_AW + 1)'(RX_DEPTH));
    end
    rx_pop = rx_read_request && !rx_empty_flag;
    next_rd = rx_pop ? rx_mem[rx_rp[RX_AW-1:0]] : rx_read_word;
    next_rx_wp = rx_wp + {{RX_AW{1'h0}}, rx_push};
    next_rx_rp = rx_rp + {{RX_AW{1'h0}}, rx_pop};
    next_cnt = next_rx_wp - next_rx_rp;
    next_empty = (next_cnt == '0);
    next_bp = ((RX_AW + 1)'(RX_DEPTH) - next_cnt) <= (RX_AW + 1)'(ddr_link_pkg::NEARLY_FULL_FREE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
      rp_bin <= '0;
      rp_gray <= '0;
      acc <= '0;
      ak <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
      rx_read_word <= '0;
      rx_empty_flag <= 1'h1;
      receiver_backpressure <= ddr_link_pkg::BP_RESET;
    end else if (ce) begin
      wg_s1 <= wp_gray;
      wg_s2 <= wg_s1;
      rp_bin <= next_rp_bin;
      rp_gray <= next_rp_bin ^ (next_rp_bin >> 1);
      acc <= next_acc;
      ak <= next_ak;
      rx_wp <= next_rx_wp;
      rx_rp <= next_rx_rp;
      rx_read_word <= next_rd;
      rx_empty_flag <= next_empty;
      receiver_backpressure <= next_bp;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && rx_push) rx_mem[rx_wp[RX_AW-1:0]] <= next_acc;
  end

  property p_flag_low_half;
    @(posedge clk) disable iff (!rst_b) !forwarded_link_clock |-> !parcel_valid_flag;
  endproperty
  a_flag_low_half: assert property (p_flag_low_half) else $error("flag high in low half");
  property p_link_toggle;
    @(posedge clk) disable iff (!rst_b) (ce && run && $past(run)) |=> (forwarded_link_clock != $past(forwarded_link_clock));
  endproperty
  a_link_toggle: assert property (p_link_toggle) else $error("link clock stalled");
  property p_full_ignored;
    @(posedge clk) disable iff (!rst_b) (ce && tx_fifo_full_flag && tx_write_request) |=> tx_cnt <= $past(tx_cnt);
  endproperty
  a_full_ignored: assert property (p_full_ignored) else $error("write taken while full");
  property p_bp_stall;
    @(posedge clk) disable iff (!rst_b) (bp_s && !busy) |-> !tx_pop;
  endproperty
  a_bp_stall: assert property (p_bp_stall) else $error("send under backpressure");
  property p_bp_out;
    @(posedge clk) disable iff (!rst_b) (ce && next_cnt >= (RX_AW + 1)'(RX_DEPTH - 32)) |=> receiver_backpressure;
  endproperty
  a_bp_out: assert property (p_bp_out) else $error("backpressure missing");
  property p_user_reset;
    @(posedge clk) disable iff (!rst_b) (ce && !(&lock_s)) |=> tx_user_reset;
  endproperty
  a_user_reset: assert property (p_user_reset) else $error("user reset released early");
  property p_far_reset;
    @(posedge clk) disable iff (!rst_b) (ce && !lock_s.link_gen) |=> far_end_reset;
  endproperty
  a_far_reset: assert property (p_far_reset) else $error("far-end reset released early");
  property p_rx_idle;
    @(posedge clk) disable iff (!rst_b) (ce && !(pf_pop && pf_flag_out)) |=> rx_wp == $past(rx_wp);
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("write without valid flag");
  property p_pf_write;
    @(posedge link_rx_clk) disable iff (!rst_b) (lce && hf && !pf_full) |=> wp_bin == $past(wp_bin) + 3'h1;
  endproperty
  a_pf_write: assert property (p_pf_write) else $error("phase slot not written");
  c_full: cover property (@(posedge clk) disable iff (!rst_b) tx_fifo_full_flag);
  c_send: cover property (@(posedge clk) disable iff (!rst_b) parcel_valid_flag);
  c_bp: cover property (@(posedge clk) disable iff (!rst_b) bp_s && !tx_empty && run);
  c_rx_word: cover property (@(posedge clk) disable iff (!rst_b) rx_push);
endmodule : ddr_fifo_chip_link

// [testbench/link_partner.sv]
// Far-end model: a remote transmitter feeding the receive side, and a remote receiver of the transmit side.
// Assumes an 8-bit link, slices of width 4, and two parcel pairs to a 32-bit user word.
`timescale 1ns/1ns
module link_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic forwarded_link_clock,
  input wire logic parcel_valid_flag,
  input wire logic [7:0] ddr_link_bus,
  input wire logic receiver_backpressure,
  output logic link_rx_clk,
  output logic rx_parcel_valid_flag,
  output logic [7:0] rx_ddr_link_bus
);
  logic [31:0] got_q[$];
  logic [15:0] pair_q[$];
  logic [15:0] cur_pair;
  logic [15:0] word_lo;
  logic [7:0] lo_half;
  logic have_lo;
  logic pair_idx;
  logic slot;
  logic sending;

  task automatic push_word(input logic [31:0] w);
    pair_q.push_back(w[15:0]);
    pair_q.push_back(w[31:16]);
  endtask : push_word

  initial begin
    link_rx_clk = 1'b0;
    #7;
    forever #15 link_rx_clk = ~link_rx_clk;
  end

  // Launch on the falling edge so parcels are settled at the sampling edge; idle lines toggle.
  always @(negedge link_rx_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot <= 1'b0;
      sending <= 1'b0;
      rx_parcel_valid_flag <= 1'b0;
      rx_ddr_link_bus <= 8'h00;
    end else if (!slot) begin
      slot <= 1'b1;
      if (pair_q.size() > 0 && (pair_q.size() % 2 == 1 || !receiver_backpressure)) begin
        cur_pair = pair_q.pop_front();
        sending <= 1'b1;
        rx_parcel_valid_flag <= 1'b1;
        rx_ddr_link_bus <= {cur_pair[11:8], cur_pair[3:0]};
      end else begin
        sending <= 1'b0;
        rx_parcel_valid_flag <= 1'b0;
        rx_ddr_link_bus <= ~rx_ddr_link_bus;
      end
    end else begin
      slot <= 1'b0;
      rx_parcel_valid_flag <= 1'b0;
      rx_ddr_link_bus <= sending ? {cur_pair[15:12], cur_pair[7:4]} : ~rx_ddr_link_bus;
    end
  end

  // Rebuilds words from the transmit side: lower half with the flag, upper half one cycle later.
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      have_lo <= 1'b0;
      pair_idx <= 1'b0;
    end else if (have_lo) begin
      have_lo <= 1'b0;
      pair_idx <= ~pair_idx;
      if (!pair_idx) begin
        word_lo <= {ddr_link_bus[7:4], lo_half[7:4], ddr_link_bus[3:0], lo_half[3:0]};
      end else begin
        got_q.push_back({ddr_link_bus[7:4], lo_half[7:4], ddr_link_bus[3:0], lo_half[3:0], word_lo});
      end
    end else if (parcel_valid_flag === 1'b1) begin
      lo_half <= ddr_link_bus;
      have_lo <= 1'b1;
    end
  end
endmodule : link_partner

// [testbench/tb.sv]
// Self-checking bench: lock sequencing, transmit stall and full, receive widening and backpressure.
// Assumes link_partner as the far end and an 8-bit link with 32-bit user words.
`timescale 1ns/1ns
module tb;
  localparam int TX_DEPTH = 8;
  localparam int RX_DEPTH = 40;
  logic clk;
  logic ce;
  logic lclk_hold;
  logic rst_b;
  ddr_link_pkg::lock_t lock_in;
  logic tx_user_reset;
  logic far_end_reset;
  logic tx_write_request;
  logic [31:0] tx_write_word;
  logic tx_fifo_full_flag;
  logic forwarded_link_clock;
  logic parcel_valid_flag;
  logic [7:0] ddr_link_bus;
  logic receiver_backpressure_in;
  logic link_rx_clk;
  logic rx_parcel_valid_flag;
  logic [7:0] rx_ddr_link_bus;
  logic receiver_backpressure;
  logic rx_read_request;
  logic [31:0] rx_read_word;
  logic rx_empty_flag;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int i;

  ddr_fifo_chip_link #(.LINK_W(8), .RATIO(2), .TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) u_ddr_fifo_chip_link (
    .clk(clk), .ce(ce), .rst_b(rst_b), .lock_in(lock_in), .tx_user_reset(tx_user_reset),
    .far_end_reset(far_end_reset), .tx_write_request(tx_write_request), .tx_write_word(tx_write_word),
    .tx_fifo_full_flag(tx_fifo_full_flag), .forwarded_link_clock(forwarded_link_clock),
    .parcel_valid_flag(parcel_valid_flag), .ddr_link_bus(ddr_link_bus),
    .receiver_backpressure_in(receiver_backpressure_in), .link_rx_clk(link_rx_clk),
    .rx_parcel_valid_flag(rx_parcel_valid_flag), .rx_ddr_link_bus(rx_ddr_link_bus),
    .receiver_backpressure(receiver_backpressure), .rx_read_request(rx_read_request),
    .rx_read_word(rx_read_word), .rx_empty_flag(rx_empty_flag));

  link_partner u_link_partner (
    .clk(clk), .rst_b(rst_b), .forwarded_link_clock(forwarded_link_clock),
    .parcel_valid_flag(parcel_valid_flag), .ddr_link_bus(ddr_link_bus),
    .receiver_backpressure(receiver_backpressure), .link_rx_clk(link_rx_clk),
    .rx_parcel_valid_flag(rx_parcel_valid_flag), .rx_ddr_link_bus(rx_ddr_link_bus));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask : chkb

  // Called just after a rising edge; the request stays up for the caller to lower.
  task automatic wr(input logic [31:0] w);
    tx_write_request <= (tx_user_reset === 1'b0);
    tx_write_word <= w;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [31:0] exp);
    int n;
    n = 0;
    do @(negedge clk); while (rx_empty_flag !== 1'b0 && ++n < 1000);
    @(posedge clk);
    rx_read_request <= 1'b1;
    @(posedge clk);
    rx_read_request <= 1'b0;
    @(negedge clk);
    chk(rx_read_word, exp);
  endtask : rd

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  // The valid flag must stay low whenever the forwarded clock is in its low half.
  always @(negedge clk) begin
    if (rst_b === 1'b1 && forwarded_link_clock === 1'b0 && parcel_valid_flag !== 1'b0) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, parcel_valid_flag, 1'b0);
    end
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    lock_in = 4'h0;
    tx_write_request = 1'b0;
    tx_write_word = 32'h0000_0000;
    receiver_backpressure_in = 1'b0;
    rx_read_request = 1'b0;
    repeat (11) @(posedge clk);
    #1;
    chkb(receiver_backpressure, 1'b1);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chkb(tx_user_reset, 1'b1);
    chkb(far_end_reset, 1'b1);
    chkb(receiver_backpressure, 1'b0);
    @(posedge clk);
    lock_in <= 4'h1;
    repeat (10) @(posedge clk);
    #1;
    chkb(far_end_reset, 1'b0);
    chkb(tx_user_reset, 1'b1);
    @(posedge clk);
    lock_in <= 4'hF;
    repeat (10) @(posedge clk);
    #1;
    chkb(tx_user_reset, 1'b0);
    // Clock enable low must freeze the running link clock for an odd number of cycles.
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    #1;
    lclk_hold = forwarded_link_clock;
    repeat (5) @(posedge clk);
    #1;
    chkb(forwarded_link_clock, lclk_hold);
    @(posedge clk);
    ce <= 1'b1;
    // Stall the sender, fill the transmit buffer and push one more word at it.
    @(posedge clk);
    receiver_backpressure_in <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i <= TX_DEPTH; i++) wr(32'hA5C3_0000 + 32'(i));
    tx_write_request <= 1'b0;
    #1;
    chkb(tx_fifo_full_flag, 1'b1);
    repeat (30) @(posedge clk);
    chk(32'(u_link_partner.got_q.size()), 32'h0000_0000);
    receiver_backpressure_in <= 1'b0;
    for (i = 0; i < 600 && u_link_partner.got_q.size() < TX_DEPTH; i++) @(posedge clk);
    repeat (100) @(posedge clk);
    #1;
    chk(32'(u_link_partner.got_q.size()), 32'(TX_DEPTH));
    for (i = 0; i < TX_DEPTH; i++) chk(u_link_partner.got_q[i], 32'hA5C3_0000 + 32'(i));
    chkb(tx_fifo_full_flag, 1'b0);
    chkb(receiver_backpressure, 1'b0);
    // Receive side: twelve words must raise backpressure and come out whole and in order.
    for (i = 0; i < 12; i++) u_link_partner.push_word(32'h3C96_0000 + 32'(i));
    for (i = 0; i < 2000 && receiver_backpressure !== 1'b1; i++) @(negedge clk);
    chkb(receiver_backpressure, 1'b1);
    for (i = 0; i < 12; i++) rd(32'h3C96_0000 + 32'(i));
    repeat (100) @(posedge clk);
    #1;
    chkb(rx_empty_flag, 1'b1);
    chkb(receiver_backpressure, 1'b0);
    @(posedge clk);
    lock_in <= 4'hD;
    repeat (10) @(posedge clk);
    #1;
    chkb(tx_user_reset, 1'b1);
    conclude();
  end
endmodule : tb
